// ==== hdl/trace_pkg.sv ====
// shared constants of the branch trace capture block
// assumes a 32-bit apb slave on pclk and a nibble-wide trace output port
package trace_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WIN_LO = 8'h04;
    localparam logic [7:0] OFS_WIN_HI = 8'h08;
    localparam logic [7:0] OFS_ASID   = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_REC0   = 8'h14;
    localparam logic [7:0] OFS_REC1   = 8'h18;
    localparam logic [7:0] OFS_REC2   = 8'h1c;
    // control fields
    localparam int CTL_EN      = 0;
    localparam int CTL_RT      = 1;
    localparam int CTL_CONT    = 2;
    localparam int CTL_BR_EN   = 3;
    localparam int CTL_RNG_EN  = 4;
    localparam int CTL_SW_EN   = 5;
    localparam int CTL_ASID_EN = 6;
    localparam int CTL_DIR_LO  = 8;
    localparam logic [9:0] CTRL_RST = 10'h000;
    // status fields
    localparam int ST_LOST    = 0;
    localparam int ST_STOPPED = 1;
    localparam int ST_LINK    = 2;
    localparam int ST_EMPTY   = 3;
    localparam int ST_STALL   = 4;
    // direction select of the range tracer
    localparam logic [1:0] DIR_READ  = 2'h1;
    localparam logic [1:0] DIR_WRITE = 2'h2;
    localparam logic [1:0] DIR_ANY   = 2'h3;
    // record layout: type, word a, word b, info byte
    localparam int REC_W    = 74;
    localparam int BUF_D    = 16;
    localparam int INSTR_BYTES_I = 2;
    localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;
    typedef enum logic [1:0] {
        REC_BRANCH = 2'h1,
        REC_RANGE  = 2'h2,
        REC_SOFT   = 2'h3
    } rec_kind_e;
    typedef enum logic [2:0] {
        BK_JUMP = 3'h0,
        BK_IF_FALSE = 3'h1,
        BK_IF_TRUE  = 3'h2,
        BK_CALL = 3'h3,
        BK_RET  = 3'h4,
        BK_EXC  = 3'h5,
        BK_INT  = 3'h6,
        BK_RESV = 3'h7
    } br_kind_e;
endpackage

// ==== hdl/trace_fifo.sv ====
// record buffer in flip-flops with valid/ready on both sides
// assumes one clock; drop_oldest lets a push into a full buffer evict the head
module trace_fifo #(
    parameter int W = 74,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    input  wire logic         drop_oldest,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    // state
    output logic              full,
    output logic              empty
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    wire           push = in_valid && in_ready;
    wire           evict = full && push && drop_oldest;
    wire           pop = (out_valid && out_ready) || evict;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    assign full      = (cnt_ff == (AW+1)'(D));
    assign empty     = (cnt_ff == '0);
    assign in_ready  = !full || drop_oldest || out_ready;
    assign out_valid = !empty;
    assign out_data  = mem_ff[rd_ff];

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= inc(wr_ff);
            if (pop) rd_ff <= inc(rd_ff);
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_ff <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule

// ==== hdl/trace_port_tx.sv ====
// serialiser of one record into nibbles on the trace output port
// assumes the emulator samples trace_data on every pclk while trace_sync marks the first nibble
module trace_port_tx #(
    parameter int W = 74
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // record in
    input  wire logic         rec_valid,
    output logic              rec_ready,
    input  wire logic [W-1:0] rec_data,
    // pins
    output logic [3:0]        trace_data,
    output logic              trace_sync,
    output logic              trace_busy
);
    localparam int NIB = (W + 3) / 4;
    localparam int CW  = $clog2(NIB + 1);
    logic [NIB*4-1:0] sh_ff;
    logic [CW-1:0]    left_ff;

    assign rec_ready  = (left_ff == '0);
    assign trace_busy = !rec_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff      <= '0;
            left_ff    <= '0;
            trace_data <= 4'h0;
            trace_sync <= 1'b0;
        end else if (rec_valid && rec_ready) begin
            sh_ff      <= {(NIB*4)'(rec_data)} >> 4;
            left_ff    <= CW'(NIB - 1);
            trace_data <= rec_data[3:0];
            trace_sync <= 1'b1;
        end else begin
            trace_sync <= 1'b0;
            trace_data <= (left_ff != '0) ? sh_ff[3:0] : 4'h0;
            sh_ff      <= sh_ff >> 4;
            if (left_ff != '0) left_ff <= left_ff - 1'b1;
        end
    end
endmodule

// ==== hdl/branch_trace_capture.sv ====
// branch, range-access and software trace capture with apb registers
// assumes the cpu holds an event stable while cpu_stall is high
// emu_present is an asynchronous pin from the external emulator
// Contract
// - branch records keep source, destination, branch kind and bus master
// - range records only for addresses inside window with chosen direction
// - asid compared only when enabled, otherwise every asid matches
// - software trace records hold instruction pc and one general register
// - completion exception during exception branch records following address
// - false/true conditional branches with zero displacement record nothing
// - reset-vector branch records nothing
// - real-time mode never stalls the cpu; excess records are dropped
// - non-real-time mode stalls the cpu until the record is accepted, in port mode only
// - continue-on-full overwrites the oldest buffered record, in buffer mode only
// - stop-on-full stops capture while cpu keeps running, in buffer mode only
module branch_trace_capture #(
    parameter int DEPTH = trace_pkg::BUF_D
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // branch event from cpu
    input  wire logic        br_valid,
    input  wire logic [31:0] br_src,
    input  wire logic [31:0] br_dst,
    input  wire logic [2:0]  br_kind,
    input  wire logic [1:0]  br_master,
    input  wire logic [7:0]  br_disp,
    input  wire logic        br_is_reset,
    input  wire logic        br_cmpl_exc,
    // memory access event
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_asid,
    // software trace event
    input  wire logic        sw_valid,
    input  wire logic [31:0] sw_pc,
    input  wire logic [31:0] sw_gpr,
    // cpu hold
    output logic             cpu_stall,
    // trace output port
    input  wire logic        emu_present,
    output logic [3:0]       trace_data,
    output logic             trace_sync
);
    localparam int W = trace_pkg::REC_W;

    // registers
    logic [9:0]  ctrl_ff;
    logic        rt_ff;
    logic        cont_ff;
    logic [31:0] win_lo_ff;
    logic [31:0] win_hi_ff;
    logic [7:0]  asid_ff;
    logic        lost_ff;
    logic        stopped_ff;
    logic        sync1_ff;
    logic        sync2_ff;
    logic        sync3_ff;
    logic        link_ff;

    // apb decode
    wire         acc_phase = psel && penable;
    wire         wr_en     = acc_phase && pwrite;
    wire         rd_en     = acc_phase && !pwrite;
    wire         hit_ctrl  = (paddr == trace_pkg::OFS_CTRL);
    wire         hit_lo    = (paddr == trace_pkg::OFS_WIN_LO);
    wire         hit_hi    = (paddr == trace_pkg::OFS_WIN_HI);
    wire         hit_asid  = (paddr == trace_pkg::OFS_ASID);
    wire         hit_stat  = (paddr == trace_pkg::OFS_STATUS);
    wire         hit_r0    = (paddr == trace_pkg::OFS_REC0);
    wire         hit_r1    = (paddr == trace_pkg::OFS_REC1);
    wire         hit_r2    = (paddr == trace_pkg::OFS_REC2);
    wire         mapped    = hit_ctrl | hit_lo | hit_hi | hit_asid | hit_stat |
                             hit_r0 | hit_r1 | hit_r2;
    wire         clr_lost  = wr_en && hit_stat && pwdata[trace_pkg::ST_LOST];
    wire         clr_stop  = wr_en && hit_stat && pwdata[trace_pkg::ST_STOPPED];
    wire         en_rise   = wr_en && hit_ctrl && pwdata[trace_pkg::CTL_EN] &&
                             !ctrl_ff[trace_pkg::CTL_EN];

    // configuration views
    wire         enable  = ctrl_ff[trace_pkg::CTL_EN];
    wire         asid_en = ctrl_ff[trace_pkg::CTL_ASID_EN];
    wire [1:0]   dir_sel = ctrl_ff[trace_pkg::CTL_DIR_LO +: 2];
    wire         port_mode = link_ff;

    // event qualification
    // zero-displacement conditionals never change flow
    wire         zero_cond = ((br_kind == trace_pkg::BK_IF_FALSE) ||
                              (br_kind == trace_pkg::BK_IF_TRUE)) && (br_disp == 8'h00);
    wire         br_take  = enable && ctrl_ff[trace_pkg::CTL_BR_EN] && br_valid &&
                            !zero_cond && !br_is_reset;
    wire         in_win   = (acc_addr >= win_lo_ff) && (acc_addr <= win_hi_ff);
    wire         dir_ok   = acc_write ? dir_sel[1] : dir_sel[0];
    wire         asid_ok  = !asid_en || (acc_asid == asid_ff);
    wire         rng_take = enable && ctrl_ff[trace_pkg::CTL_RNG_EN] && acc_valid &&
                            in_win && dir_ok && asid_ok;
    wire         sw_take  = enable && ctrl_ff[trace_pkg::CTL_SW_EN] && sw_valid;
    // a completion exception has already retired the faulting instruction
    wire [31:0]  br_addr  = (br_cmpl_exc && br_kind == trace_pkg::BK_EXC) ?
                            br_src + trace_pkg::INSTR_BYTES : br_src;

    function automatic logic [W-1:0] pack(input logic [1:0] k, input logic [31:0] a,
                                          input logic [31:0] b, input logic [7:0] i);
        pack = {k, a, b, i};
    endfunction

    // one record per cycle: branch first, then range, then software
    wire [W-1:0] br_rec  = pack(trace_pkg::REC_BRANCH, br_addr, br_dst,
                                {br_kind, br_master, 3'h0});
    wire [W-1:0] rng_rec = pack(trace_pkg::REC_RANGE, acc_addr, 32'h0000_0000,
                                {acc_write, 7'h00} | {1'b0, acc_asid[6:0]});
    wire [W-1:0] sw_rec  = pack(trace_pkg::REC_SOFT, sw_pc, sw_gpr, 8'h00);
    wire         cand    = br_take || rng_take || sw_take;
    wire [W-1:0] cand_rec = br_take ? br_rec : (rng_take ? rng_rec : sw_rec);
    wire         multi   = (br_take && (rng_take || sw_take)) || (rng_take && sw_take);

    // buffer and port
    logic        f_in_ready;
    logic        f_out_valid;
    logic [W-1:0] f_out_data;
    logic        f_full;
    logic        f_empty;
    logic        tx_ready;
    logic        tx_busy;
    logic        pop_rd;

    // stop-on-full only governs buffer mode; the port drains continuously
    wire         stop_hold = !port_mode && stopped_ff;
    wire         push      = cand && !stop_hold;
    wire         drop_old  = !port_mode && cont_ff;
    wire         accepted  = push && f_in_ready;
    wire         hit_full  = !port_mode && !cont_ff && f_full && cand;

    assign cpu_stall = port_mode && !rt_ff && push && !f_in_ready;
    assign pop_rd    = rd_en && hit_r2;

    trace_fifo #(
        .W (W),
        .D (DEPTH)
    ) u_fifo (
        .pclk        (pclk),
        .presetn     (presetn),
        .in_valid    (push),
        .in_ready    (f_in_ready),
        .in_data     (cand_rec),
        .drop_oldest (drop_old),
        .out_valid   (f_out_valid),
        .out_ready   (port_mode ? tx_ready : pop_rd),
        .out_data    (f_out_data),
        .full        (f_full),
        .empty       (f_empty)
    );

    trace_port_tx #(
        .W (W)
    ) u_tx (
        .pclk       (pclk),
        .presetn    (presetn),
        .rec_valid  (f_out_valid && port_mode),
        .rec_ready  (tx_ready),
        .rec_data   (f_out_data),
        .trace_data (trace_data),
        .trace_sync (trace_sync),
        .trace_busy (tx_busy)
    );

    // apb answer, zero wait states
    wire [31:0] status = {27'h0, cpu_stall, f_empty, link_ff, stopped_ff, lost_ff};
    // in buffer mode rec2 pops the head, so rec0 and rec1 must be read first
    wire [31:0] rd_mux = hit_ctrl ? {22'h0, ctrl_ff[9:3], cont_ff, rt_ff, enable} :
                         hit_lo   ? win_lo_ff :
                         hit_hi   ? win_hi_ff :
                         hit_asid ? {24'h0, asid_ff} :
                         hit_stat ? status :
                         hit_r0   ? f_out_data[71:40] :
                         hit_r1   ? f_out_data[39:8] :
                         hit_r2   ? {22'h0, f_out_data[73:72], f_out_data[7:0]} :
                         32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = acc_phase && !mapped;
    assign prdata  = rd_mux;

    // emulator presence: three stages, change taken when the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            link_ff  <= 1'b0;
        end else begin
            sync1_ff <= emu_present;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) link_ff <= sync3_ff;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= trace_pkg::CTRL_RST;
            rt_ff     <= 1'b0;
            cont_ff   <= 1'b0;
            win_lo_ff <= 32'h0000_0000;
            win_hi_ff <= 32'h0000_0000;
            asid_ff   <= 8'h00;
        end else begin
            if (wr_en && hit_ctrl) ctrl_ff <= pwdata[9:0];
            if (wr_en && hit_lo) win_lo_ff <= pwdata;
            if (wr_en && hit_hi) win_hi_ff <= pwdata;
            if (wr_en && hit_asid) asid_ff <= pwdata[7:0];
            if (en_rise) begin
                rt_ff   <= pwdata[trace_pkg::CTL_RT];
                cont_ff <= pwdata[trace_pkg::CTL_CONT];
            end
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_ff    <= 1'b0;
            stopped_ff <= 1'b0;
        end else begin
            if ((port_mode && rt_ff && push && !f_in_ready) || multi) begin
                lost_ff <= 1'b1;
            end else if (clr_lost) begin
                lost_ff <= 1'b0;
            end
            if (hit_full) begin
                stopped_ff <= 1'b1;
            end else if (clr_stop) begin
                stopped_ff <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_zero_disp: assert property (
        (br_valid && zero_cond && !rng_take && !sw_take) |-> !push)
        else $error("zero-displacement branch was recorded");
    chk_reset_branch: assert property (
        (br_valid && br_is_reset && !rng_take && !sw_take) |-> !push)
        else $error("reset branch was recorded");
    chk_exc_addr: assert property (
        (br_take && br_cmpl_exc && br_kind == trace_pkg::BK_EXC) |->
        cand_rec[71:40] == br_src + trace_pkg::INSTR_BYTES)
        else $error("exception branch address not advanced");
    chk_branch_fields: assert property (
        br_take |-> cand_rec[39:8] == br_dst && cand_rec[7:3] == {br_kind, br_master})
        else $error("branch record fields wrong");
    chk_soft_record: assert property (
        (sw_take && !br_take && !rng_take) |->
        cand_rec[71:40] == sw_pc && cand_rec[39:8] == sw_gpr)
        else $error("software record fields wrong");

    chk_range_window: assert property (
        (rng_take) |-> (acc_addr >= win_lo_ff && acc_addr <= win_hi_ff &&
        (dir_sel == trace_pkg::DIR_ANY || dir_sel[acc_write]))) 
        else $error("range record outside window or direction");
    chk_asid_dontcare: assert property (
        (!asid_en && enable && ctrl_ff[trace_pkg::CTL_RNG_EN] && acc_valid &&
         in_win && dir_ok) |-> rng_take)
        else $error("asid filtered while not enabled");

    chk_rt_no_stall: assert property (
        rt_ff |-> !cpu_stall)
        else $error("cpu stalled in real-time mode");
    chk_nrt_stall: assert property (
        (port_mode && !rt_ff && push && !f_in_ready) |-> cpu_stall)
        else $error("record refused without stall");
    chk_cont_accept: assert property (
        (!port_mode && cont_ff && f_full && push) |=> f_full)
        else $error("overwrite did not keep buffer full");
    chk_stop_hold: assert property (
        (stopped_ff && !port_mode && !clr_stop) |=> stopped_ff && !cpu_stall)
        else $error("stop-on-full released or stalled");

    chk_port_link: assert property (
        !link_ff |=> !trace_sync)
        else $error("trace port started without emulator");
    chk_mode_stable: assert property (
        (enable && !en_rise) |=> $stable(rt_ff) && $stable(cont_ff))
        else $error("policy changed while enabled");

    // capture gating and the flags behind it
    chk_stop_no_push: assert property (
        stop_hold |-> !push)
        else $error("record taken while stopped");
    chk_stall_cause: assert property (
        cpu_stall |-> f_full && tx_busy)
        else $error("stall without a pending record");
    chk_rt_lost_flag: assert property (
        (port_mode && rt_ff && push && !f_in_ready) |=> lost_ff)
        else $error("dropped record not flagged");
    chk_full_stop_flag: assert property (
        hit_full |=> stopped_ff)
        else $error("full buffer did not stop");

    // record contents and asid filtering beyond the checks above
    chk_branch_src: assert property (
        (br_take && br_kind != trace_pkg::BK_EXC) |->
        cand_rec[71:40] == br_src)
        else $error("branch source not recorded");
    chk_range_dir_bit: assert property (
        (rng_take && !br_take) |-> cand_rec[7] == acc_write)
        else $error("range direction bit wrong");
    chk_asid_filter: assert property (
        (asid_en && acc_asid != asid_ff) |-> !rng_take)
        else $error("asid mismatch recorded");
    chk_soft_kind: assert property (
        (sw_take && !br_take && !rng_take) |-> cand_rec[73:72] == trace_pkg::REC_SOFT)
        else $error("software record kind wrong");

    // port start
    chk_port_start: assert property (
        (f_out_valid && port_mode && tx_ready) |=> trace_sync)
        else $error("head record not started on port");

    cov_branch: cover property (br_take && accepted);
    cov_stall: cover property (cpu_stall [*3]);
    cov_overwrite: cover property (!port_mode && cont_ff && f_full && push);
    cov_stop: cover property ($rose(stopped_ff));
endmodule

// ==== bench/emu_link.sv ====
// emulator-side model of the trace output port: rebuilds each record
// assumes nibbles arrive lsb first, one per pclk, trace_sync on the first
module emu_link (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // attach control from the bench
    input  wire logic        attach,
    // trace output port
    input  wire logic [3:0]  trace_data,
    input  wire logic        trace_sync,
    output logic             emu_present,
    // rebuilt records
    output logic [75:0]      last_rec,
    output int               n_rec
);
    logic [75:0] acc;
    int          cnt;

    // the stream only exists while this model is attached
    assign emu_present = attach;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 19;
            n_rec <= 0;
            acc <= '0;
            last_rec <= '0;
        end else if (trace_sync === 1'b1) begin
            acc <= 76'(trace_data);
            cnt <= 1;
        end else if (cnt < 19) begin
            acc[cnt*4 +: 4] <= trace_data;
            cnt <= cnt + 1;
            if (cnt == 18) begin
                last_rec <= {trace_data, acc[71:0]};
                n_rec <= n_rec + 1;
            end
        end
    end
endmodule

// ==== bench/branch_trace_capture_tb.sv ====
// self-checking bench: apb register tasks plus cpu event stimulus
// assumes apb pready within 49 access cycles and an emulator model on the trace output port
module branch_trace_capture_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 0, presetn = 0, attach = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, d;
    logic        pready, pslverr, er, cpu_stall, emu_present, trace_sync;
    logic        br_valid = 0, acc_valid = 0, sw_valid = 0;
    logic [78:0] brq = 0;
    logic [40:0] accq = 0;
    logic [63:0] swq = 0;
    logic [3:0]  trace_data;
    logic [75:0] last_rec;
    int          n_rec, n_fail = 0, n_tests = 0, n_stall = 0, i, s0;

    branch_trace_capture #(.DEPTH(4)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .br_valid, .br_src(brq[78:47]), .br_dst(brq[46:15]),
        .br_kind(brq[14:12]), .br_master(brq[11:10]), .br_disp(brq[9:2]),
        .br_is_reset(brq[1]), .br_cmpl_exc(brq[0]), .acc_valid, .acc_addr(accq[40:9]),
        .acc_write(accq[8]), .acc_asid(accq[7:0]), .sw_valid, .sw_pc(swq[63:32]),
        .sw_gpr(swq[31:0]), .cpu_stall, .emu_present, .trace_data, .trace_sync
    );
    emu_link u_emu (.pclk, .presetn, .attach, .trace_data, .trace_sync, .emu_present,
                    .last_rec, .n_rec);

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (cpu_stall === 1'b1) n_stall <= n_stall + 1;

    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tmo();
        chk("wait bound", 32'h0, 32'h1);
        end_sim();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic se);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) tmo();
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v, d, er);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, d, er);
        if (e !== 32'hffffffff) chk(nm, e, d);
    endtask

    // all-ones expectation means that word is not compared
    task automatic rec_chk(input logic [31:0] e0, e1, e2);
        rchk("rec0", trace_pkg::OFS_REC0, e0);
        rchk("rec1", trace_pkg::OFS_REC1, e1);
        rchk("rec2", trace_pkg::OFS_REC2, e2);
    endtask

    // sel picks sw, range, branch; the event is held while the cpu is stalled
    task automatic ev(input logic [2:0] sel, input logic [78:0] v);
        int  n;
        logic st;
        n = 0;
        brq <= v;
        accq <= v[40:0];
        swq <= v[63:0];
        {sw_valid, acc_valid, br_valid} <= sel;
        do begin
            @(negedge pclk);
            st = cpu_stall;
            @(posedge pclk);
            n++;
        end while (st === 1'b1 && n < 500);
        {sw_valid, acc_valid, br_valid} <= 3'b000;
        if (n >= 500) tmo();
        @(posedge pclk);
    endtask

    task automatic jb(input logic [31:0] s);
        ev(3'b001, {s, 32'h2000, 3'h0, 2'h1, 8'h04, 2'b00});
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("ctrl reset", trace_pkg::OFS_CTRL, 32'h0);
        rchk("status reset", trace_pkg::OFS_STATUS, 32'h8);
        apb(1'b0, 8'h20, 32'h0, d, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, d);
        wr(trace_pkg::OFS_CTRL, 32'h29);
        ev(3'b001, {32'h1000, 32'h2000, trace_pkg::BK_IF_FALSE, 2'h2, 8'h00, 2'b00});
        ev(3'b001, {32'h1000, 32'h2000, trace_pkg::BK_IF_TRUE, 2'h2, 8'h00, 2'b00});
        ev(3'b001, {32'h1000, 32'ha0000000, trace_pkg::BK_JUMP, 2'h2, 8'h04, 2'b10});
        rchk("nothing kept", trace_pkg::OFS_STATUS, 32'h8);
        ev(3'b001, {32'h1000, 32'h2000, trace_pkg::BK_CALL, 2'h2, 8'h04, 2'b00});
        ev(3'b001, {32'h3000, 32'h2000, trace_pkg::BK_EXC, 2'h1, 8'h04, 2'b01});
        ev(3'b100, {15'h0, 32'h4444, 32'h5555});
        rec_chk(32'h1000, 32'h2000, 32'h170);
        rec_chk(32'h3002, 32'h2000, 32'h1a8);
        rec_chk(32'h4444, 32'h5555, 32'h300);
        wr(trace_pkg::OFS_WIN_LO, 32'h100);
        wr(trace_pkg::OFS_WIN_HI, 32'h1ff);
        wr(trace_pkg::OFS_ASID, 32'h7);
        wr(trace_pkg::OFS_CTRL, 32'h0);
        wr(trace_pkg::OFS_CTRL, 32'h211);
        ev(3'b010, {38'h0, 32'h1ff, 1'b1, 8'h05});
        ev(3'b010, {38'h0, 32'h200, 1'b1, 8'h05});
        ev(3'b010, {38'h0, 32'h100, 1'b0, 8'h05});
        rec_chk(32'h1ff, 32'hffffffff, 32'h285);
        rchk("range empty", trace_pkg::OFS_STATUS, 32'h8);
        wr(trace_pkg::OFS_CTRL, 32'h0);
        wr(trace_pkg::OFS_CTRL, 32'h151);
        ev(3'b010, {38'h0, 32'h150, 1'b0, 8'h05});
        ev(3'b010, {38'h0, 32'h150, 1'b0, 8'h07});
        ev(3'b010, {38'h0, 32'h150, 1'b1, 8'h07});
        rec_chk(32'h150, 32'hffffffff, 32'h207);
        rchk("asid empty", trace_pkg::OFS_STATUS, 32'h8);
        wr(trace_pkg::OFS_CTRL, 32'h0);
        wr(trace_pkg::OFS_CTRL, 32'h09);
        for (i = 0; i < 5; i++) jb(i);
        rchk("stop status", trace_pkg::OFS_STATUS, 32'hffffffff);
        chk("stopped", 32'h1, {31'h0, d[1]});
        rec_chk(32'h0, 32'h2000, 32'hffffffff);
        wr(trace_pkg::OFS_STATUS, 32'h3);
        wr(trace_pkg::OFS_CTRL, 32'h0);
        wr(trace_pkg::OFS_CTRL, 32'h0d);
        for (i = 0; i < 5; i++) jb(32'h10 + i);
        for (i = 1; i < 5; i++) rec_chk(32'h10 + i, 32'h2000, 32'hffffffff);
        rchk("drained", trace_pkg::OFS_STATUS, 32'h8);
        attach <= 1'b1;
        repeat (8) @(posedge pclk);
        rchk("link", trace_pkg::OFS_STATUS, 32'hffffffff);
        chk("link bit", 32'h1, {31'h0, d[2]});
        wr(trace_pkg::OFS_CTRL, 32'h0);
        wr(trace_pkg::OFS_CTRL, 32'h09);
        s0 = n_stall;
        for (i = 0; i < 8; i++) jb(32'h1000 + i);
        for (i = 0; i < 400 && n_rec < 8; i++) @(posedge pclk);
        if (n_rec < 8) tmo();
        chk("port a", 32'h1007, last_rec[71:40]);
        chk("port b", 32'h2000, last_rec[39:8]);
        chk("port tail", 32'h108, {20'h0, last_rec[75:72], last_rec[7:0]});
        chk("stalled", 32'h1, {31'h0, n_stall > s0});
        wr(trace_pkg::OFS_STATUS, 32'h3);
        wr(trace_pkg::OFS_CTRL, 32'h0);
        wr(trace_pkg::OFS_CTRL, 32'h0b);
        s0 = n_stall;
        for (i = 0; i < 12; i++) jb(32'h500 + i);
        repeat (300) @(posedge pclk);
        chk("rt no stall", 32'h0, n_stall - s0);
        rchk("rt status", trace_pkg::OFS_STATUS, 32'hffffffff);
        chk("rt lost", 32'h1, {31'h0, d[0]});
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        tmo();
    end
endmodule
